// ### logic/hic_pkg.sv
// shared constants and types of the homing and in-position control block
`default_nettype none
package hic_pkg;

   localparam int CLK_NS = 10;

   // register byte offsets
   localparam logic [7:0] OFS_REF_OFFSET = 8'h00;
   localparam logic [7:0] OFS_HOME_DIR   = 8'h04;
   localparam logic [7:0] OFS_HOME_MODE  = 8'h08;
   localparam logic [7:0] OFS_HOME_VEL   = 8'h0C;
   localparam logic [7:0] OFS_CREEP_VEL  = 8'h10;
   localparam logic [7:0] OFS_INPOS_LIM  = 8'h14;
   localparam logic [7:0] OFS_SETTLE     = 8'h18;
   localparam logic [7:0] OFS_COMMAND    = 8'h1C;
   localparam logic [7:0] OFS_DEG_STEP   = 8'h20;
   localparam logic [7:0] OFS_STATUS     = 8'h24;
   localparam logic [7:0] OFS_DEG_POS    = 8'h28;
   localparam logic [7:0] OFS_PIN_LEVEL  = 8'h2C;
   localparam logic [7:0] OFS_PIN_FUNC   = 8'h30;
   localparam logic [7:0] OFS_IN_POLAR   = 8'h34;

   // command register bits
   localparam int CMD_START_BIT  = 0;
   localparam int CMD_ADJUST_BIT = 1;
   localparam int CMD_TEACH_BIT  = 2;

   // status register bits
   localparam int ST_BUSY_BIT    = 0;
   localparam int ST_HOMED_BIT   = 1;
   localparam int ST_INPOS_BIT   = 2;
   localparam int ST_ADJDONE_BIT = 3;
   localparam int ST_REFUSED_BIT = 4;
   localparam int ST_RANGE_BIT   = 5;

   // ranges and reset values (velocities in 0.001 rev/s)
   localparam int REF_OFFSET_MAX = 262144000;
   localparam int REF_OFFSET_RST = 0;
   localparam int HOME_VEL_MIN   = 1;
   localparam int HOME_VEL_MAX   = 10000;
   localparam int HOME_VEL_RST   = 200;
   localparam int CREEP_VEL_MIN  = 1;
   localparam int CREEP_VEL_MAX  = 200;
   localparam int CREEP_VEL_RST  = 10;
   localparam int DEG_STEP_MAX   = 3600000;
   localparam int DEG_PER_REV    = 36000;
   localparam int INPOS_LIM_MAX  = 2621439;
   localparam int INPOS_LIM_RST  = 400;
   localparam int HOME_MODE_MAX  = 1;
   localparam logic HOME_DIR_RST = 1'b1;
   localparam logic signed [31:0] SEEK_LEAD = 32'sh2;
   localparam int SETTLE_RST     = 100;

   // input debounce and output stability times
   localparam int DEBOUNCE_NS   = 20000;
   localparam int DEBOUNCE_CYC  = (DEBOUNCE_NS / CLK_NS < 1) ? 1 : DEBOUNCE_NS / CLK_NS;
   localparam int OUT_STABLE_NS = 10000;
   localparam int OUT_STABLE_CYC = (OUT_STABLE_NS / CLK_NS < 1) ? 1 : OUT_STABLE_NS / CLK_NS;

   typedef enum logic {MODE_SENSOR, MODE_INDEX} hic_mode_type;

   typedef enum {ST_IDLE, ST_SEEK, ST_INDEX, ST_OFFSET, ST_STEP} hic_state_type;

   typedef struct packed {
      logic               servo_on;
      logic               other_motion;
      logic               alarm_halt;
      logic               stop_input;
   } hic_cond_type;

   typedef struct packed {
      logic               active;
      logic               dir_minus;
      logic [13:0]        vel;
      logic signed [31:0] target;
   } hic_motion_type;

endpackage
`default_nettype wire

// ### logic/hic_stable.sv
// condition stability timer: output rises once a condition has held for a set count
`timescale 1ns/10ps
`default_nettype none
module hic_stable
   import hic_pkg::*;
#(
   parameter int W = 24
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic         cond,
   input  wire logic [W-1:0] limit,
   output var  logic         stable_q
);

   logic [W-1:0] cnt_q;

   // the count saturates, so a long hold never wraps back to low
   always_ff @(posedge clock) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (!cond) begin
         cnt_q <= '0;
      end else if (cnt_q < limit) begin
         cnt_q <= cnt_q + W'(1);
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         stable_q <= 1'b0;
      end else begin
         stable_q <= cond && (cnt_q >= limit);
      end
   end

   drop_on_loss_a : assert property (@(posedge clock) disable iff (rst)
      !cond |=> !stable_q) else $error("stable output held after condition lost");

endmodule
`default_nettype wire

// ### logic/hic_home_ctrl.sv
// homing, degree stepping, in-position and port monitor control block
//
// Overview of operation
// - home is the sensor point or first index after it, shifted by offset
// - reference offset spans plus/minus 262144000 pulses, reset 0, sign vs homing dir
// - teach captures signed travel from sensor point to present position
// - homing start runs the selected mode; adjust variant runs sensor adjust
// - sensor-adjust run ends at the home point without the offset move
// - start and degree step need servo on, idle, no halt, stop off
// - homing velocity 0.001 to 10.000 rev/s, reset 0.200
// - homing velocity writes act on a running homing move at once
// - creep velocity 0.001 to 0.200 rev/s, reset 0.010, index approach
// - degree step moves relative up to 3600000 hundredths of a degree
// - degree readout gives present position in hundredths of a degree
// - in-position rises after error stays inside limit for settle time
// - in-position limit 0 to 2621439 pulses, reset 400
// - level monitor: inputs 1 on, outputs 1 closed, one bit per port
// - function monitor shows ports after polarity, debounce and stability
// - homing direction 0 plus, 1 minus, reset 1, taken at next run
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module hic_home_ctrl
   import hic_pkg::*;
#(
   parameter int PULSES_PER_REV = 2621440,
   parameter int NIN            = 8,
   parameter int NOUT           = 3
) (
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire logic [7:0]         addr,
   input  wire logic [31:0]        wdata,
   input  wire logic               wr,
   input  wire logic               rd,
   output var  logic [31:0]        rdata_q,
   input  wire hic_cond_type       cond,
   input  wire logic               home_sensor,
   input  wire logic               index_pulse,
   input  wire logic signed [31:0] position,
   input  wire logic signed [31:0] pos_error,
   input  wire logic [NIN-1:0]     port_in,
   output var  hic_motion_type     motion_q,
   output var  logic [NOUT-1:0]    port_out_q,
   output var  logic               inpos_output
);

   function automatic logic in_range(input logic signed [31:0] v, input int lo, input int hi);
      return (v >= lo) && (v <= hi);
   endfunction

   function automatic logic signed [31:0] dir_apply(input logic minus,
                                                    input logic signed [31:0] v);
      return minus ? -v : v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////////////
   hic_state_type      state_q;
   logic signed [31:0] ref_offset_q;
   logic               home_dir_q;
   hic_mode_type       home_mode_q;
   logic [13:0]        home_vel_q;
   logic [13:0]        creep_vel_q;
   logic [21:0]        inpos_lim_q;
   logic [23:0]        settle_q;
   logic [NIN-1:0]     in_polar_q;
   logic               run_dir_q;
   hic_mode_type       run_mode_q;
   logic               adj_run_q;
   logic               adj_done_q;
   logic               homed_q;
   logic signed [31:0] sens_pos_q;
   logic signed [31:0] target_q;
   logic               refused_q;
   logic               range_q;
   logic signed [31:0] deg_pos_q;
   logic [NIN-1:0]     in_func_q;

   logic               wr_cmd;
   logic               wr_step;
   logic               accept;
   logic               start_req;
   logic               step_req;
   logic               teach_req;
   logic               step_ok;
   logic               halt;
   logic               home_hit;
   logic signed [31:0] teach_val;
   logic signed [31:0] step_pulses;
   logic signed [63:0] step_wide;

   assign wr_cmd    = wr && (addr == OFS_COMMAND);
   assign wr_step   = wr && (addr == OFS_DEG_STEP);
   assign accept    = cond.servo_on && !cond.other_motion && (state_q == ST_IDLE)
                      && !cond.alarm_halt && !cond.stop_input;
   assign start_req = wr_cmd && wdata[CMD_START_BIT];
   assign teach_req = wr_cmd && wdata[CMD_TEACH_BIT];
   assign step_ok   = in_range(wdata, -DEG_STEP_MAX, DEG_STEP_MAX);
   assign step_req  = wr_step && step_ok;
   assign halt      = !cond.servo_on || cond.alarm_halt || cond.stop_input;
   // travel from the sensor point, positive along the homing direction
   assign teach_val = dir_apply(home_dir_q, position - sens_pos_q);
   assign home_hit  = ((state_q == ST_SEEK) && home_sensor && (run_mode_q == MODE_SENSOR))
                      || ((state_q == ST_INDEX) && index_pulse);
   assign step_wide = (64'($signed(wdata)) * 64'(DEG_PER_REV == 0 ? 1 : PULSES_PER_REV))
                      / 64'(DEG_PER_REV);
   assign step_pulses = step_wide[31:0];

   ////////////////////////////////////////////////////////////////////////////////////////
   // parameter registers; a bad value leaves the old setting in place
   always_ff @(posedge clock) begin
      if (rst) begin
         ref_offset_q <= 32'(REF_OFFSET_RST);
         home_dir_q   <= HOME_DIR_RST;
         home_mode_q  <= MODE_SENSOR;
         home_vel_q   <= 14'(HOME_VEL_RST);
         creep_vel_q  <= 14'(CREEP_VEL_RST);
         inpos_lim_q  <= 22'(INPOS_LIM_RST);
         settle_q     <= 24'(SETTLE_RST);
         in_polar_q   <= '0;
      end else if (wr) begin
         case (addr)
            OFS_REF_OFFSET: if (in_range(wdata, -REF_OFFSET_MAX, REF_OFFSET_MAX)) begin
               ref_offset_q <= wdata;
            end
            OFS_HOME_DIR: if (in_range(wdata, 0, 1)) begin
               home_dir_q <= wdata[0];
            end
            OFS_HOME_MODE: if (in_range(wdata, 0, HOME_MODE_MAX)) begin
               home_mode_q <= hic_mode_type'(wdata[0]);
            end
            OFS_HOME_VEL: if (in_range(wdata, HOME_VEL_MIN, HOME_VEL_MAX)) begin
               home_vel_q <= wdata[13:0];
            end
            OFS_CREEP_VEL: if (in_range(wdata, CREEP_VEL_MIN, CREEP_VEL_MAX)) begin
               creep_vel_q <= wdata[13:0];
            end
            OFS_INPOS_LIM: if (in_range(wdata, 0, INPOS_LIM_MAX)) begin
               inpos_lim_q <= wdata[21:0];
            end
            OFS_SETTLE: if (wdata[31:24] == 8'h00) begin
               settle_q <= wdata[23:0];
            end
            OFS_IN_POLAR: begin
               in_polar_q <= wdata[NIN-1:0];
            end
            OFS_COMMAND: if (teach_req && (state_q == ST_IDLE) && adj_done_q
                             && in_range(teach_val, -REF_OFFSET_MAX, REF_OFFSET_MAX)) begin
               ref_offset_q <= teach_val;
            end
            default: begin
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // homing and stepping sequencer
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q    <= ST_IDLE;
         run_dir_q  <= HOME_DIR_RST;
         run_mode_q <= MODE_SENSOR;
         adj_run_q  <= 1'b0;
         adj_done_q <= 1'b0;
         homed_q    <= 1'b0;
         sens_pos_q <= '0;
         target_q   <= '0;
      end else if (halt && (state_q != ST_IDLE)) begin
         state_q <= ST_IDLE;
      end else if (home_hit) begin
         // a sensor-mode hit skips the seek branch, so the sensor point is latched here
         sens_pos_q <= (state_q == ST_SEEK) ? position : sens_pos_q;
         if (adj_run_q || (ref_offset_q == 0)) begin
            state_q    <= ST_IDLE;
            homed_q    <= 1'b1;
            adj_done_q <= adj_run_q;
         end else begin
            state_q  <= ST_OFFSET;
            target_q <= position + dir_apply(run_dir_q, ref_offset_q);
         end
      end else begin
         case (state_q)
            ST_IDLE: if (start_req && accept) begin
               state_q    <= ST_SEEK;
               run_dir_q  <= home_dir_q;
               run_mode_q <= home_mode_q;
               adj_run_q  <= wdata[CMD_ADJUST_BIT];
               homed_q    <= 1'b0;
               adj_done_q <= 1'b0;
            end else if (step_req && accept) begin
               state_q  <= ST_STEP;
               target_q <= position + step_pulses;
            end
            ST_SEEK: if (home_sensor) begin
               sens_pos_q <= position;
               state_q    <= ST_INDEX;
            end
            ST_INDEX: begin
            end
            ST_OFFSET, ST_STEP: if (position == target_q) begin
               state_q <= ST_IDLE;
               homed_q <= homed_q || (state_q == ST_OFFSET);
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // motion command; velocity follows the live register, so a rewrite acts at once
   always_ff @(posedge clock) begin
      if (rst) begin
         motion_q <= '0;
      end else begin
         motion_q.active <= (state_q != ST_IDLE);
         // seek and index runs chase a point just ahead, so the far side keeps turning
         motion_q.target <= ((state_q == ST_SEEK) || (state_q == ST_INDEX))
                            ? position + dir_apply(run_dir_q, SEEK_LEAD) : target_q;
         case (state_q)
            ST_SEEK: begin
               motion_q.vel       <= home_vel_q;
               motion_q.dir_minus <= run_dir_q;
            end
            ST_INDEX: begin
               motion_q.vel       <= creep_vel_q;
               motion_q.dir_minus <= run_dir_q;
            end
            ST_OFFSET, ST_STEP: begin
               motion_q.vel       <= home_vel_q;
               motion_q.dir_minus <= target_q < position;
            end
            default: begin
               motion_q.vel       <= '0;
               motion_q.dir_minus <= 1'b0;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // sticky flags are cleared by a status read; a new event in that cycle wins
   always_ff @(posedge clock) begin
      if (rst) begin
         refused_q <= 1'b0;
         range_q   <= 1'b0;
      end else begin
         refused_q <= ((start_req || step_req) && !accept)
                      || (refused_q && !(rd && (addr == OFS_STATUS)));
         range_q   <= (wr_step && !step_ok)
                      || (range_q && !(rd && (addr == OFS_STATUS)));
      end
   end

   always_ff @(posedge clock) begin
      if (rst) begin
         deg_pos_q <= '0;
      end else begin
         deg_pos_q <= 32'((64'(position) * 64'(DEG_PER_REV)) / 64'(PULSES_PER_REV));
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // input function: polarity then debounce; output function: condition after stability
   for (genvar i = 0; i < NIN; i++) begin : g_in
      logic [11:0] db_cnt_q;
      logic        pol;
      assign pol = port_in[i] ^ in_polar_q[i];
      always_ff @(posedge clock) begin
         if (rst) begin
            db_cnt_q     <= '0;
            in_func_q[i] <= 1'b0;
         end else if (pol == in_func_q[i]) begin
            db_cnt_q <= '0;
         end else if (db_cnt_q >= 12'(DEBOUNCE_CYC - 1)) begin
            db_cnt_q     <= '0;
            in_func_q[i] <= pol;
         end else begin
            db_cnt_q <= db_cnt_q + 12'h001;
         end
      end
   end

   logic [2:0] out_cond;
   assign out_cond = {inpos_output, homed_q, state_q != ST_IDLE};

   for (genvar j = 0; j < NOUT; j++) begin : g_out
      hic_stable #(.W(12)) u_stab (
         .clock    (clock),
         .rst      (rst),
         .cond     (out_cond[j % 3]),
         .limit    (12'(OUT_STABLE_CYC)),
         .stable_q (port_out_q[j])
      );
   end

   logic [31:0] abs_err;
   assign abs_err = pos_error[31] ? 32'(-pos_error) : 32'(pos_error);

   hic_stable #(.W(24)) u_inpos (
      .clock    (clock),
      .rst      (rst),
      .cond     (abs_err <= 32'(inpos_lim_q)),
      .limit    (settle_q),
      .stable_q (inpos_output)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // read port: data only in the cycle after the strobe, zero elsewhere and when unmapped
   always_ff @(posedge clock) begin
      if (rst || !rd) begin
         rdata_q <= '0;
      end else begin
         case (addr)
            OFS_REF_OFFSET: rdata_q <= ref_offset_q;
            OFS_HOME_DIR:   rdata_q <= {31'h00000000, home_dir_q};
            OFS_HOME_MODE:  rdata_q <= {31'h00000000, home_mode_q};
            OFS_HOME_VEL:   rdata_q <= {18'h00000, home_vel_q};
            OFS_CREEP_VEL:  rdata_q <= {18'h00000, creep_vel_q};
            OFS_INPOS_LIM:  rdata_q <= {10'h000, inpos_lim_q};
            OFS_SETTLE:     rdata_q <= {8'h00, settle_q};
            OFS_STATUS:     rdata_q <= {26'h0000000, range_q, refused_q, adj_done_q,
                                        inpos_output, homed_q, state_q != ST_IDLE};
            OFS_DEG_POS:    rdata_q <= deg_pos_q;
            OFS_PIN_LEVEL:  rdata_q <= 32'({port_out_q, port_in});
            OFS_PIN_FUNC:   rdata_q <= 32'({port_out_q, in_func_q});
            OFS_IN_POLAR:   rdata_q <= 32'(in_polar_q);
            default:        rdata_q <= '0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   refuse_hold_a : assert property (@(posedge clock) disable iff (rst)
      (start_req || step_req) && !accept && !halt |=> state_q == $past(state_q))
      else $error("refused command changed the sequencer");
   start_seek_a : assert property (@(posedge clock) disable iff (rst)
      start_req && accept |=> state_q == ST_SEEK ##1 motion_q.active)
      else $error("accepted start did not begin a seek");
   live_vel_a : assert property (@(posedge clock) disable iff (rst)
      state_q == ST_SEEK && $past(state_q == ST_SEEK) |=> motion_q.vel == $past(home_vel_q))
      else $error("seek velocity not following register");
   creep_vel_a : assert property (@(posedge clock) disable iff (rst)
      state_q == ST_INDEX |=> motion_q.vel == $past(creep_vel_q))
      else $error("index approach not at creep velocity");
   adjust_no_ofs_a : assert property (@(posedge clock) disable iff (rst)
      state_q == ST_OFFSET |-> !adj_run_q)
      else $error("sensor adjust run made the offset move");
   vel_range_a : assert property (@(posedge clock) disable iff (rst)
      wr && addr == OFS_HOME_VEL && wdata > HOME_VEL_MAX |=> home_vel_q == $past(home_vel_q))
      else $error("out of range velocity was stored");
   dir_latched_a : assert property (@(posedge clock) disable iff (rst)
      state_q != ST_IDLE && $past(state_q != ST_IDLE) |-> run_dir_q == $past(run_dir_q))
      else $error("homing direction changed mid run");
   teach_store_a : assert property (@(posedge clock) disable iff (rst)
      teach_req && state_q == ST_IDLE && adj_done_q
      && in_range(teach_val, -REF_OFFSET_MAX, REF_OFFSET_MAX) |=> ref_offset_q == $past(teach_val))
      else $error("teach did not capture travel");

endmodule
`default_nettype wire

// ### verification/hic_motor_model.sv
// motor and home sensor model on the far side of the motion port
`timescale 1ns/10ps
`default_nettype none
module hic_motor_model
   import hic_pkg::*;
(
   input  wire logic               clock,
   input  wire logic               rst,
   input  wire hic_motion_type     motion_q,
   output var  logic signed [31:0] position,
   output var  logic               home_sensor,
   output var  logic               index_pulse,
   output var  logic signed [31:0] pos_error
);
   // one pulse a cycle keeps moves short; the servo stops once it sits on the target
   always_ff @(posedge clock) begin
      if (rst) begin
         position <= 32'sh0;
      end else if (motion_q.active && (position != motion_q.target)) begin
         position <= motion_q.dir_minus ? position - 32'sh1 : position + 32'sh1;
      end
   end
   // narrow window, so a run that adds an offset move ends outside it
   assign home_sensor = (position <= -32'sh28) && (position > -32'sh3C);
   assign index_pulse = home_sensor && (position[2:0] == 3'h0);
   // error stays above the limit while moving
   assign pos_error = motion_q.active ? 32'sh1F4 : 32'sh0;
endmodule
`default_nettype wire

// ### verification/tb_hic_home_ctrl.sv
// self-checking bench for the homing and in-position control block
`timescale 1ns/10ps
`default_nettype none
module tb_hic_home_ctrl
   import hic_pkg::*;
;
   logic               clock = 1'b0;
   logic               rst = 1'b1;
   logic [7:0]         addr = 8'h00;
   logic [31:0]        wdata = 32'h0;
   logic               wr = 1'b0;
   logic               rd = 1'b0;
   logic [31:0]        rdata_q;
   hic_cond_type       cond = 4'h8;
   logic               home_sensor;
   logic               index_pulse;
   logic signed [31:0] position;
   logic signed [31:0] pos_error;
   logic [7:0]         port_in = 8'hA5;
   hic_motion_type     motion_q;
   logic [2:0]         port_out_q;
   logic               inpos_output;
   int                 bad_count = 0;
   int                 compares = 0;
   int                 cycles = 0;
   logic [31:0]        r;
   logic [31:0]        p0;

   // one pulse per revolution step of 0.01 degree keeps degree moves short
   hic_home_ctrl #(.PULSES_PER_REV(36000)) dut (.clock(clock), .rst(rst), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q), .cond(cond),
      .home_sensor(home_sensor), .index_pulse(index_pulse), .position(position),
      .pos_error(pos_error), .port_in(port_in), .motion_q(motion_q),
      .port_out_q(port_out_q), .inpos_output(inpos_output));
   hic_motor_model model (.clock(clock), .rst(rst), .motion_q(motion_q),
      .position(position), .home_sensor(home_sensor), .index_pulse(index_pulse),
      .pos_error(pos_error));

   initial begin
      forever #5 clock = ~clock;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         final_report();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(posedge clock);
      d = rdata_q;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rreg(a, r);
      chk(r & m, e);
   endtask
   task automatic wc(input logic [7:0] a, input logic [31:0] v, input logic [31:0] e);
      wreg(a, v);
      rchk(a, 32'hFFFFFFFF, e);
   endtask
   // bounded wait, so a run that never ends shows up as a mismatch later
   task automatic wait_idle;
      repeat (3) @(posedge clock);
      for (int i = 0; i < 3000 && motion_q.active; i++) @(posedge clock);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (16) @(posedge clock);
      rst <= 1'b0;
      rchk(OFS_REF_OFFSET, 32'hFFFFFFFF, 32'h0);
      rchk(OFS_HOME_DIR, 32'hFFFFFFFF, 32'h1);
      rchk(OFS_HOME_VEL, 32'hFFFFFFFF, 32'hC8);
      rchk(OFS_CREEP_VEL, 32'hFFFFFFFF, 32'hA);
      rchk(OFS_INPOS_LIM, 32'hFFFFFFFF, 32'h190);
      wc(OFS_HOME_VEL, 32'h2710, 32'h2710);
      wc(OFS_HOME_VEL, 32'h2711, 32'h2710);
      wc(OFS_HOME_VEL, 32'h0, 32'h2710);
      wc(OFS_CREEP_VEL, 32'hC9, 32'hA);
      wc(OFS_INPOS_LIM, 32'h27FFFF, 32'h27FFFF);
      wc(OFS_INPOS_LIM, 32'h280000, 32'h27FFFF);
      wc(OFS_REF_OFFSET, 32'hF0600000, 32'hF0600000);
      wc(OFS_REF_OFFSET, 32'hF05FFFFF, 32'hF0600000);
      wc(OFS_HOME_DIR, 32'h2, 32'h1);
      wreg(OFS_REF_OFFSET, 32'h0);
      wreg(OFS_INPOS_LIM, 32'h190);
      wreg(OFS_SETTLE, 32'h14);
      $display("test settings done");
      for (int i = 0; i < 4; i++) begin
         cond <= 4'h8 ^ (4'h8 >> i);
         wreg(OFS_COMMAND, 32'h1);
         repeat (3) @(posedge clock);
         chk({31'h0, motion_q.active}, 32'h0);
         rchk(OFS_STATUS, 32'h11, 32'h10);
      end
      cond <= 4'h8;
      wreg(OFS_DEG_STEP, 32'h36EE81);
      rchk(OFS_STATUS, 32'h21, 32'h20);
      $display("test refusals done");
      wreg(OFS_COMMAND, 32'h1);
      repeat (4) @(posedge clock);
      chk({16'h0, motion_q.active, motion_q.dir_minus, motion_q.vel}, 32'hE710);
      chk({31'h0, inpos_output}, 32'h0);
      wreg(OFS_HOME_VEL, 32'h12C);
      repeat (2) @(posedge clock);
      chk({18'h0, motion_q.vel}, 32'h12C);
      wait_idle;
      rchk(OFS_STATUS, 32'h3, 32'h2);
      repeat (25) @(posedge clock);
      chk({31'h0, inpos_output}, 32'h1);
      $display("test homing done");
      rreg(OFS_DEG_POS, p0);
      chk(p0, position);
      wreg(OFS_DEG_STEP, 32'hFFFFFF9C);
      repeat (3) @(posedge clock);
      chk(motion_q.target, p0 - 32'h64);
      chk({31'h0, motion_q.dir_minus}, 32'h1);
      wait_idle;
      wreg(OFS_DEG_STEP, 32'hC8);
      repeat (3) @(posedge clock);
      chk({31'h0, motion_q.dir_minus}, 32'h0);
      wait_idle;
      rchk(OFS_DEG_POS, 32'hFFFFFFFF, p0 + 32'h64);
      $display("test degree step done");
      wreg(OFS_REF_OFFSET, 32'h1E);
      wreg(OFS_COMMAND, 32'h3);
      wait_idle;
      chk({31'h0, home_sensor}, 32'h1);
      rchk(OFS_STATUS, 32'h9, 32'h8);
      $display("test adjust done");
      wreg(OFS_DEG_STEP, 32'h1E);
      wait_idle;
      wreg(OFS_COMMAND, 32'h4);
      rchk(OFS_REF_OFFSET, 32'hFFFFFFFF, 32'hFFFFFFE4);
      $display("test teach done");
      wreg(OFS_HOME_MODE, 32'h1);
      wreg(OFS_COMMAND, 32'h1);
      wait_idle;
      rchk(OFS_STATUS, 32'h3, 32'h2);
      rchk(OFS_DEG_POS, 32'hFFFFFFFF, 32'hFFFFFFEC);
      $display("test index homing done");
      wreg(OFS_IN_POLAR, 32'hF);
      repeat (2100) @(posedge clock);
      rchk(OFS_PIN_LEVEL, 32'h5FF, 32'h4A5);
      rchk(OFS_PIN_FUNC, 32'h5FF, 32'h4AA);
      $display("test monitors done");
      final_report();
   end
endmodule
`default_nettype wire
